/* parity_csr_defs.vh */
// parity_csr_defs.vh: bit positions, widths and reset values of the parity control/status register
// assumes: included by the parity csr design files only
`ifndef PARITY_CSR_DEFS_VH
`define PARITY_CSR_DEFS_VH

`define CSR_WIDTH 16
`define CSR_ERR_BIT 15
`define CSR_SEL_BIT 14
`define CSR_ADDR_LO 5
`define CSR_ADDR_HI 11
`define CSR_WRONG_PAR_BIT 2
`define CSR_UNUSED_BIT 1
`define CSR_REPORT_EN_BIT 0
`define LOW_FAIL_MSB 17
`define LOW_FAIL_LSB 11
`define HIGH_FAIL_MSB 21
`define HIGH_FAIL_LSB 18
`define BUS_ADDR_WIDTH 22
`define CTRL_RESET 1'b0

`endif

/* fail_addr_latch.v */
// fail_addr_latch.v: holds the address bits of the last failing read
// assumes: same clock as the register logic; capture is a one-cycle pulse
`default_nettype none
`include "parity_csr_defs.vh"

module fail_addr_latch (
  input wire mclk,
  input wire capture,
  input wire [`BUS_ADDR_WIDTH-1:0] failAddr,
  output reg [6:0] lowFailedAddressBits_q,
  output reg [3:0] highFailedAddressBits_q
);

  // no reset on purpose: the failed address must survive nrst and bus initialise
  always @(posedge mclk) begin
    if (capture) begin
      lowFailedAddressBits_q <= failAddr[`LOW_FAIL_MSB:`LOW_FAIL_LSB];
      highFailedAddressBits_q <= failAddr[`HIGH_FAIL_MSB:`HIGH_FAIL_LSB];
    end
  end

endmodule // fail_addr_latch
`default_nettype wire

/* memory_parity_csr_diag.v */
// memory_parity_csr_diag.v: parity control/status register, wrong-parity forcing and error reporting
// assumes: memory cycles and register accesses come in on mclk as one-cycle strobes from the bus front end
`default_nettype none
`include "parity_csr_defs.vh"

module memory_parity_csr_diag (
  input wire mclk,
  input wire nrst,
  input wire busInit,
  input wire csrWrite,
  input wire csrRead,
  input wire [`CSR_WIDTH-1:0] csrWrData,
  output reg [`CSR_WIDTH-1:0] csrRdData,
  input wire wordWriteCycle,
  input wire byteWriteCycle,
  input wire [1:0] byteSel,
  input wire [`CSR_WIDTH-1:0] memWrData,
  output wire [1:0] parityToStore,
  input wire readCycle,
  input wire readModifyWriteCycle,
  input wire [`BUS_ADDR_WIDTH-1:0] memAddr,
  input wire [1:0] storedParity,
  input wire [`CSR_WIDTH-1:0] memRdData,
  output reg dataLineSixteenOut,
  output reg dataLineSeventeenOut,
  output reg dataLineSixteenOe_n,
  output reg dataLineSeventeenOe_n,
  output wire errorLed
);

  reg wrongParity_q;
  reg reportEn_q;
  reg addrSel_q;
  reg parityErr_q;
  wire [6:0] lowBits;
  wire [3:0] highBits;
  wire readAny;
  wire [1:0] checkParity;
  wire parityFail;
  wire initNow;

  // odd parity per byte
  function oddPar;
    input [7:0] b;
    begin
      oddPar = ~(^b);
    end
  endfunction

  assign initNow = ~nrst | busInit;
  assign readAny = readCycle | readModifyWriteCycle;

  // parity is generated for both bytes; the memory array stores only the lanes it writes
  assign parityToStore[0] = oddPar(memWrData[7:0]) ^ (wrongParity_q & (wordWriteCycle | (byteWriteCycle & byteSel[0])));
  assign parityToStore[1] = oddPar(memWrData[15:8]) ^ (wrongParity_q & (wordWriteCycle | (byteWriteCycle & byteSel[1])));

  assign checkParity[0] = oddPar(memRdData[7:0]);
  assign checkParity[1] = oddPar(memRdData[15:8]);
  assign parityFail = readAny & (checkParity != storedParity);

  always @(posedge mclk) begin
    if (initNow) begin
      wrongParity_q <= `CTRL_RESET;
      reportEn_q <= `CTRL_RESET;
      addrSel_q <= `CTRL_RESET;
      parityErr_q <= `CTRL_RESET;
    end else begin
      if (csrWrite) begin
        wrongParity_q <= csrWrData[`CSR_WRONG_PAR_BIT];
        reportEn_q <= csrWrData[`CSR_REPORT_EN_BIT];
        addrSel_q <= csrWrData[`CSR_SEL_BIT];
        parityErr_q <= csrWrData[`CSR_ERR_BIT];
      end
      // a new error wins over a software clear in the same cycle
      if (parityFail) begin
        parityErr_q <= 1'b1;
      end
    end
  end

  fail_addr_latch u_fail_addr_latch (
    .mclk(mclk),
    .capture(parityFail),
    .failAddr(memAddr),
    .lowFailedAddressBits_q(lowBits),
    .highFailedAddressBits_q(highBits)
  );

  // error lines are driven low (asserted) for one cycle, the cycle after a failing read, only while report enable is set
  always @(posedge mclk) begin
    if (initNow) begin
      dataLineSixteenOut <= 1'b1;
      dataLineSeventeenOut <= 1'b1;
      dataLineSixteenOe_n <= 1'b1;
      dataLineSeventeenOe_n <= 1'b1;
    end else if (parityFail & reportEn_q) begin
      dataLineSixteenOut <= 1'b0;
      dataLineSeventeenOut <= 1'b0;
      dataLineSixteenOe_n <= 1'b0;
      dataLineSeventeenOe_n <= 1'b0;
    end else begin
      dataLineSixteenOut <= 1'b1;
      dataLineSeventeenOut <= 1'b1;
      dataLineSixteenOe_n <= 1'b1;
      dataLineSeventeenOe_n <= 1'b1;
    end
  end

  // read data registered; write-path bits not listed read as zero, bit 01 included
  always @(posedge mclk) begin
    if (initNow) begin
      csrRdData <= 16'h0000;
    end else if (csrRead) begin
      csrRdData <= 16'h0000;
      csrRdData[`CSR_ERR_BIT] <= parityErr_q;
      csrRdData[`CSR_SEL_BIT] <= addrSel_q;
      if (addrSel_q) begin
        csrRdData[`CSR_ADDR_LO+3:`CSR_ADDR_LO] <= highBits;
      end else begin
        csrRdData[`CSR_ADDR_HI:`CSR_ADDR_LO] <= lowBits;
      end
      csrRdData[`CSR_WRONG_PAR_BIT] <= wrongParity_q;
      csrRdData[`CSR_REPORT_EN_BIT] <= reportEn_q;
    end
  end

  assign errorLed = parityErr_q;

endmodule // memory_parity_csr_diag
`default_nettype wire

/* parity_csr_asserts.sv */
// checker on the parity csr top ports
// assumes: bound to the design top
`default_nettype none
module parity_csr_asserts(input wire mclk, nrst, busInit, csrWrite, csrRead, readCycle, readModifyWriteCycle,
  input wire [15:0] csrRdData, input wire dataLineSixteenOut, dataLineSeventeenOut, dataLineSixteenOe_n,
  input wire dataLineSeventeenOe_n, errorLed);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_init_clear: assert property (busInit |=> !csrRdData && !errorLed && dataLineSixteenOe_n)
    else $error("init");
  chk_line_pulse: assert property (!dataLineSixteenOe_n |=> dataLineSixteenOe_n) else $error("held");
  chk_line_pair: assert property ({dataLineSixteenOut, dataLineSeventeenOut, dataLineSeventeenOe_n}
    == {3{dataLineSixteenOe_n}}) else $error("pair");
  chk_line_cause: assert property ($fell(dataLineSixteenOe_n) |-> $past(readCycle | readModifyWriteCycle))
    else $error("cause");
  chk_led_error: assert property (!dataLineSixteenOe_n |-> errorLed) else $error("led");
  chk_led_hold: assert property (errorLed && !csrWrite && !busInit |=> errorLed) else $error("drop");
  chk_unused_zero: assert property (!csrRdData[13:12] && !csrRdData[4:3] && !csrRdData[1])
    else $error("unused");
  chk_read_hold: assert property (!csrRead && !busInit |=> $stable(csrRdData)) else $error("hold");
endmodule // parity_csr_asserts
bind memory_parity_csr_diag parity_csr_asserts chk(.*);
`default_nettype wire

/* parity_store_model.sv */
// parity storage beside the data memory
// assumes: only address bits 21 and 11 decoded, enough for the two test places
`default_nettype none
module parity_store_model(input wire logic mclk, wr, input wire logic [21:0] a, input wire logic [1:0] pt,
  output logic [1:0] ps);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] mem [4];
  always @(posedge mclk) if (wr) mem[{a[21], a[11]}] <= pt;
  assign ps = mem[{a[21], a[11]}];
endmodule // parity_store_model
`default_nettype wire

/* memory_parity_csr_diag_bench.sv */
// parity csr bench
// assumes: strobes already decoded; parity store model stands in for the memory
`default_nettype none
module memory_parity_csr_diag_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, nrst = 1'b0, busInit = 1'b0, csrWrite = 1'b0, csrRead = 1'b0, wr = 1'b0, rd = 1'b0;
  logic bw = 1'b0, rmw = 1'b0, anyWr;
  logic [15:0] wd = 16'h0, q, d = 16'h5a3c;
  logic [21:0] a = 22'h0;
  logic [1:0] pt, ps;
  logic s6, s7, o6, o7, led;
  int errorCnt = 0, checked = 0;
  always #12.5 mclk = ~mclk;
  memory_parity_csr_diag DUT(.mclk, .nrst, .busInit, .csrWrite, .csrRead, .csrWrData(wd), .csrRdData(q),
    .wordWriteCycle(wr), .byteWriteCycle(bw), .byteSel(2'h3), .memWrData(d), .parityToStore(pt), .readCycle(rd),
    .readModifyWriteCycle(rmw), .memAddr(a), .storedParity(ps), .memRdData(d), .dataLineSixteenOut(s6),
    .dataLineSeventeenOut(s7), .dataLineSixteenOe_n(o6), .dataLineSeventeenOe_n(o7), .errorLed(led));
  assign anyWr = wr | bw;
  parity_store_model MEM(.mclk, .wr(anyWr), .a, .pt, .ps);
  // k: 0 csr write, 1 csr read, 2 word write, 3 read, 4 bus initialise, 5 byte write, 6 read-modify-write
  task automatic cyc(input int k, input logic [21:0] ad, input logic [15:0] v);
    logic [15:0] g;
    a <= ad;
    wd <= v;
    {csrWrite, csrRead, wr, rd, busInit, bw, rmw} <= 7'h40 >> k;
    @(posedge mclk) {csrWrite, csrRead, wr, rd, busInit, bw, rmw} <= 7'h0;
    // outputs launched at this edge are looked at once settled
    #1 g = (k == 1) ? q : {12'h0, o6, o7, s6, s7};
    if (k == 1 || k == 3 || k == 6) begin
      checked++;
      if (g !== v) begin
        errorCnt++;
        $display("MISMATCH %0t got %h exp %h", $time, g, v);
      end
    end
    @(posedge mclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #5000;
    errorCnt++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    // the failed address is unknown until the first error, so a forced parity error on a read comes before any csr read
    cyc(0, 22'h0, 16'h0005);
    cyc(2, 22'h0, 16'h0);
    cyc(2, 22'h2aa800, 16'h0);
    cyc(3, 22'h0, 16'h0000);
    cyc(1, 22'h0, 16'h8005);
    cyc(0, 22'h0, 16'h001f);
    cyc(1, 22'h0, 16'h0005);
    cyc(3, 22'h2aa800, 16'h0000);
    cyc(1, 22'h0, 16'h8aa5);
    cyc(0, 22'h0, 16'h4005);
    cyc(1, 22'h0, 16'h4145);
    $display("self-test done");
    cyc(4, 22'h0, 16'h0);
    cyc(1, 22'h0, 16'h0aa0);
    cyc(3, 22'h2aa800, 16'h000f);
    cyc(1, 22'h0, 16'h8aa0);
    cyc(0, 22'h0, 16'h0001);
    cyc(2, 22'h2aa800, 16'h0);
    cyc(3, 22'h2aa800, 16'h000f);
    cyc(1, 22'h0, 16'h0aa1);
    $display("init and report done");
    cyc(0, 22'h0, 16'h0005);
    cyc(5, 22'h2aa800, 16'h0);
    cyc(6, 22'h2aa800, 16'h0000);
    cyc(1, 22'h0, 16'h8aa5);
    $display("byte write and read-modify-write done");
    give_verdict;
  end
endmodule // memory_parity_csr_diag_bench
`default_nettype wire
